// ===== flash_ctrl_pkg.sv
package flash_ctrl_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_OP_ADDRESS      = 12'h000;
  localparam logic [11:0] OFF_OP_DATA         = 12'h004;
  localparam logic [11:0] OFF_OP_CONTROL      = 12'h008;
  localparam logic [11:0] OFF_READ_PROTECT    = 12'h130;
  localparam logic [11:0] OFF_PROGRAM_PROTECT = 12'h134;
  localparam logic [11:0] OFF_TICK_RELOAD     = 12'h140;

  // field positions and widths
  localparam int unsigned KEY_LSB             = 16;
  localparam int unsigned KEY_W               = 16;
  localparam int unsigned BIT_WORD_WRITE      = 0;
  localparam int unsigned BIT_PAGE_ERASE      = 1;
  localparam int unsigned MASS_ERASE_BIT      = 2;
  localparam int unsigned PROTECTION_COMMIT_BIT = 3;
  localparam int unsigned OP_BITS_W           = 4;
  localparam int unsigned COMMIT_SEL_BIT      = 0;
  localparam int unsigned OFFSET_W            = 12;
  localparam int unsigned PROTECT_W           = 4;
  localparam int unsigned RELOAD_W            = 8;
  localparam int unsigned BLOCK_LSB           = 10;

  localparam logic [KEY_W-1:0] CONTROL_WRITE_KEY = 16'ha442;

  // values after reset
  localparam logic [PROTECT_W-1:0] PROTECT_RST = 4'hf;
  localparam logic [RELOAD_W-1:0]  RELOAD_RST  = 8'h13;
  localparam logic [OFFSET_W-1:0]  OFFSET_RST  = 12'h000;
  localparam logic [31:0]          DATA_RST    = 32'h0000_0000;

  // operation durations in microsecond ticks
  localparam int unsigned WORD_WRITE_TIME_US = 50;
  localparam int unsigned COMMIT_TIME_US     = 50;
  localparam int unsigned PAGE_ERASE_TIME_US = 25000;
  localparam int unsigned MASS_ERASE_TIME_US = 250000;
  localparam int unsigned US_CNT_W           = 18;

  typedef enum logic [1:0] {
    OP_WORD_WRITE,
    OP_PAGE_ERASE,
    OP_MASS_ERASE,
    OP_COMMIT
  } flash_op_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PULSE,
    SEQ_FINISH
  } seq_state_t;

  // command toward the flash array
  typedef struct packed {
    logic                 active;
    flash_op_t            op;
    logic [OFFSET_W-1:0]  offset;
    logic [31:0]          data;
    logic [PROTECT_W-1:0] erase_mask;
  } flash_cmd_t;

  // write toward the nonvolatile protection copies
  typedef struct packed {
    logic                 strobe;
    logic                 sel_program;
    logic [PROTECT_W-1:0] value;
  } nv_commit_t;

endpackage

// ===== flash_program_erase_protect_ctrl.sv
// What this block does
// - two protection registers, one bit per 1 KB block in bits 3:0
// - both protection registers load from nonvolatile copies at power-on reset
// - unprogrammed protection bits read one; field resets to all ones
// - software writes may only clear protection bits, never set them
// - uncommitted clears revert at power-on; committed clears persist
// - 8-bit tick reload in bits 7:0, reset value 0x13
// - address register holds 12-bit offset in bits 11:0
// - data register supplies program word, ignored on erase
// - valid control write starts operation at address register location
// - control write without key 0xA442 ignored; key field reads zero
// - writing zero leaves op bit; bit reads one while pending, self-clears
// - commit bit 3 stores selected protection register, up to 50 us
// - mass-erase bit 2 erases every block whose program bit is set, up to 250 ms
// - page-erase bit 1 erases addressed page, up to 25 ms
// - word-write bit 0 programs data word at address, up to 50 us
// - for commit, address bit 0 one picks program, zero picks read register
// - program or erase of a block with program bit cleared is blocked
// - data read of read-protected block refused and returns zeros; fetch allowed
`timescale 1ns/1ps
module flash_program_erase_protect_ctrl #(
  parameter int unsigned WORD_WRITE_US = flash_ctrl_pkg::WORD_WRITE_TIME_US,
  parameter int unsigned COMMIT_US     = flash_ctrl_pkg::COMMIT_TIME_US,
  parameter int unsigned PAGE_ERASE_US = flash_ctrl_pkg::PAGE_ERASE_TIME_US,
  parameter int unsigned MASS_ERASE_US = flash_ctrl_pkg::MASS_ERASE_TIME_US
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [3:0]                 nv_read_protect,
  input  wire logic [3:0]                 nv_program_protect,
  output flash_ctrl_pkg::flash_cmd_t      flash_cmd,
  output flash_ctrl_pkg::nv_commit_t      nv_commit,
  input  wire logic                       rd_valid,
  input  wire logic                       rd_fetch,
  input  wire logic [11:0]                rd_offset,
  input  wire logic [31:0]                rd_array_data,
  output logic      [31:0]                rd_data,
  output logic                            rd_refused
);

  localparam int unsigned UW = flash_ctrl_pkg::US_CNT_W;

  logic [3:0]                  read_protect_ff;
  logic [3:0]                  program_protect_ff;
  logic                        loaded_ff;
  logic [7:0]                  reload_ff;
  logic [11:0]                 offset_ff;
  logic [31:0]                 data_ff;
  logic [3:0]                  op_bits_ff;
  flash_ctrl_pkg::seq_state_t  state_ff;
  logic [7:0]                  tick_cnt_ff;
  logic [UW-1:0]               us_left_ff;
  flash_ctrl_pkg::flash_cmd_t  flash_cmd_ff;
  flash_ctrl_pkg::nv_commit_t  nv_commit_ff;
  logic [31:0]                 prdata_ff;
  logic                        pready_ff;
  logic                        pslverr_ff;
  logic [31:0]                 rd_data_ff;
  logic                        rd_refused_ff;

  logic                        wr_fire;
  logic                        ctrl_wr;
  logic                        key_ok;
  logic                        start;
  flash_ctrl_pkg::flash_op_t   nxt_op;
  logic [3:0]                  nxt_op_bit;
  logic [UW-1:0]               nxt_us;
  logic                        target_locked;
  logic                        tick;
  logic                        mapped;
  logic [31:0]                 nxt_prdata;

  assign wr_fire = psel && penable && pready_ff && pwrite;
  assign ctrl_wr = wr_fire && (paddr == flash_ctrl_pkg::OFF_OP_CONTROL);
  assign key_ok  = pwdata[flash_ctrl_pkg::KEY_LSB +: flash_ctrl_pkg::KEY_W] == flash_ctrl_pkg::CONTROL_WRITE_KEY;
  // a zero bit starts nothing; further starts are ignored while one is pending
  assign start   = ctrl_wr && key_ok && (state_ff == flash_ctrl_pkg::SEQ_IDLE) && (|pwdata[3:0]);
  assign tick    = (state_ff == flash_ctrl_pkg::SEQ_PULSE) && (tick_cnt_ff == 8'h00);

  // several bits at once is a software error; commit takes precedence
  always_comb begin
    nxt_op     = flash_ctrl_pkg::OP_WORD_WRITE;
    nxt_op_bit = 4'h1;
    nxt_us     = UW'(WORD_WRITE_US);
    if (pwdata[flash_ctrl_pkg::PROTECTION_COMMIT_BIT]) begin
      nxt_op     = flash_ctrl_pkg::OP_COMMIT;
      nxt_op_bit = 4'h8;
      nxt_us     = UW'(COMMIT_US);
    end else if (pwdata[flash_ctrl_pkg::MASS_ERASE_BIT]) begin
      nxt_op     = flash_ctrl_pkg::OP_MASS_ERASE;
      nxt_op_bit = 4'h4;
      nxt_us     = UW'(MASS_ERASE_US);
    end else if (pwdata[flash_ctrl_pkg::BIT_PAGE_ERASE]) begin
      nxt_op     = flash_ctrl_pkg::OP_PAGE_ERASE;
      nxt_op_bit = 4'h2;
      nxt_us     = UW'(PAGE_ERASE_US);
    end
  end

  // word writes and page erases aimed at a locked block never reach the array
  assign target_locked = (nxt_op == flash_ctrl_pkg::OP_WORD_WRITE || nxt_op == flash_ctrl_pkg::OP_PAGE_ERASE)
                         && !program_protect_ff[offset_ff[flash_ctrl_pkg::BLOCK_LSB +: 2]];

  // protection bits: reset to open, then loaded once from the nonvolatile copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_protect_ff    <= flash_ctrl_pkg::PROTECT_RST;
      program_protect_ff <= flash_ctrl_pkg::PROTECT_RST;
      loaded_ff          <= 1'b0;
    end else if (!loaded_ff) begin
      read_protect_ff    <= nv_read_protect;
      program_protect_ff <= nv_program_protect;
      loaded_ff          <= 1'b1;
    end else if (wr_fire && paddr == flash_ctrl_pkg::OFF_READ_PROTECT) begin
      read_protect_ff    <= read_protect_ff & pwdata[3:0];
    end else if (wr_fire && paddr == flash_ctrl_pkg::OFF_PROGRAM_PROTECT) begin
      program_protect_ff <= program_protect_ff & pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_ff <= flash_ctrl_pkg::RELOAD_RST;
      offset_ff <= flash_ctrl_pkg::OFFSET_RST;
      data_ff   <= flash_ctrl_pkg::DATA_RST;
    end else if (wr_fire) begin
      if (paddr == flash_ctrl_pkg::OFF_TICK_RELOAD)
        reload_ff <= pwdata[7:0];
      if (paddr == flash_ctrl_pkg::OFF_OP_ADDRESS)
        offset_ff <= pwdata[11:0];
      if (paddr == flash_ctrl_pkg::OFF_OP_DATA)
        data_ff <= pwdata;
    end
  end

  // operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= flash_ctrl_pkg::SEQ_IDLE;
      op_bits_ff <= 4'h0;
      us_left_ff <= '0;
    end else begin
      unique case (state_ff)
        flash_ctrl_pkg::SEQ_IDLE: begin
          if (start) begin
            op_bits_ff <= nxt_op_bit;
            us_left_ff <= nxt_us;
            state_ff   <= target_locked ? flash_ctrl_pkg::SEQ_FINISH : flash_ctrl_pkg::SEQ_PULSE;
          end
        end
        flash_ctrl_pkg::SEQ_PULSE: begin
          if (tick) begin
            us_left_ff <= us_left_ff - UW'(1);
            if (us_left_ff <= UW'(1))
              state_ff <= flash_ctrl_pkg::SEQ_FINISH;
          end
        end
        flash_ctrl_pkg::SEQ_FINISH: begin
          op_bits_ff <= 4'h0;
          state_ff   <= flash_ctrl_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // reload+1 clock cycles per microsecond, restarting with every operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= flash_ctrl_pkg::RELOAD_RST;
    end else if (state_ff != flash_ctrl_pkg::SEQ_PULSE || tick_cnt_ff == 8'h00) begin
      tick_cnt_ff <= reload_ff;
    end else begin
      tick_cnt_ff <= tick_cnt_ff - 8'h01;
    end
  end

  // array command stands for the whole timed pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cmd_ff <= '0;
    end else if (state_ff == flash_ctrl_pkg::SEQ_IDLE && start && !target_locked) begin
      flash_cmd_ff.active     <= 1'b1;
      flash_cmd_ff.op         <= nxt_op;
      flash_cmd_ff.offset     <= offset_ff;
      flash_cmd_ff.data       <= data_ff;
      flash_cmd_ff.erase_mask <= program_protect_ff;
    end else if (tick && us_left_ff <= UW'(1)) begin
      flash_cmd_ff.active     <= 1'b0;
    end
  end

  // one-cycle strobe; the local copy already holds the cleared value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_commit_ff <= '0;
    end else begin
      nv_commit_ff.strobe <= start && nxt_op == flash_ctrl_pkg::OP_COMMIT;
      if (start && nxt_op == flash_ctrl_pkg::OP_COMMIT) begin
        nv_commit_ff.sel_program <= offset_ff[flash_ctrl_pkg::COMMIT_SEL_BIT];
        nv_commit_ff.value       <= offset_ff[flash_ctrl_pkg::COMMIT_SEL_BIT] ?
                                    program_protect_ff : read_protect_ff;
      end
    end
  end

  // data reads from the array, gated by read protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_ff    <= 32'h0000_0000;
      rd_refused_ff <= 1'b0;
    end else if (rd_valid) begin
      if (rd_fetch || read_protect_ff[rd_offset[flash_ctrl_pkg::BLOCK_LSB +: 2]]) begin
        rd_data_ff    <= rd_array_data;
        rd_refused_ff <= 1'b0;
      end else begin
        rd_data_ff    <= 32'h0000_0000;
        rd_refused_ff <= 1'b1;
      end
    end else begin
      rd_refused_ff <= 1'b0;
    end
  end

  // apb: no wait states, read data captured in the setup cycle
  always_comb begin
    mapped     = 1'b1;
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      flash_ctrl_pkg::OFF_OP_ADDRESS:      nxt_prdata = {20'h00000, offset_ff};
      flash_ctrl_pkg::OFF_OP_DATA:         nxt_prdata = data_ff;
      flash_ctrl_pkg::OFF_OP_CONTROL:      nxt_prdata = {28'h0000000, op_bits_ff};
      flash_ctrl_pkg::OFF_READ_PROTECT:    nxt_prdata = {28'h0000000, read_protect_ff};
      flash_ctrl_pkg::OFF_PROGRAM_PROTECT: nxt_prdata = {28'h0000000, program_protect_ff};
      flash_ctrl_pkg::OFF_TICK_RELOAD:     nxt_prdata = {24'h000000, reload_ff};
      default:                             mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
        prdata_ff <= nxt_prdata;
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign flash_cmd  = flash_cmd_ff;
  assign nv_commit  = nv_commit_ff;
  assign rd_data    = rd_data_ff;
  assign rd_refused = rd_refused_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PROTECT_ONLY_CLEARS: assert property (
    loaded_ff && $past(loaded_ff) |-> ((read_protect_ff & ~$past(read_protect_ff)) == 4'h0) &&
                                      ((program_protect_ff & ~$past(program_protect_ff)) == 4'h0))
    else $error("protection bit went from zero to one");

  AST_POR_LOAD: assert property (
    $rose(loaded_ff) |-> read_protect_ff == $past(nv_read_protect) &&
                         program_protect_ff == $past(nv_program_protect))
    else $error("protection not loaded from nonvolatile copy");

  AST_BAD_KEY_IGNORED: assert property (
    ctrl_wr && !key_ok && state_ff == flash_ctrl_pkg::SEQ_IDLE |=> op_bits_ff == 4'h0 && !flash_cmd_ff.active)
    else $error("control write without key started an operation");

  AST_KEY_READS_ZERO: assert property (
    psel && penable && pready_ff && !pwrite && paddr == flash_ctrl_pkg::OFF_OP_CONTROL |-> prdata_ff[31:4] == 28'h0)
    else $error("control key field read nonzero");

  AST_TICK_RELOADS: assert property (
    tick ##1 state_ff == flash_ctrl_pkg::SEQ_PULSE |-> tick_cnt_ff == $past(reload_ff))
    else $error("tick counter not reloaded after tick");

  AST_LOCKED_BLOCKED: assert property (
    start && target_locked |=> !flash_cmd_ff.active [*2] ##0 op_bits_ff == 4'h0)
    else $error("locked block reached the array");

  AST_OP_BIT_PENDING: assert property (
    start && !target_locked |=> op_bits_ff == $past(nxt_op_bit) && flash_cmd_ff.active)
    else $error("operation bit not pending during operation");

  AST_SELF_CLEAR: assert property (
    state_ff == flash_ctrl_pkg::SEQ_FINISH |=> op_bits_ff == 4'h0 && !flash_cmd_ff.active)
    else $error("operation bit failed to self-clear");

  AST_COMMIT_VALUE: assert property (
    nv_commit_ff.strobe |-> nv_commit_ff.value == (nv_commit_ff.sel_program ? program_protect_ff : read_protect_ff))
    else $error("commit carried wrong register");

  AST_WRITE_DATA: assert property (
    $rose(flash_cmd_ff.active) && flash_cmd_ff.op == flash_ctrl_pkg::OP_WORD_WRITE |->
      flash_cmd_ff.data == data_ff && flash_cmd_ff.offset == offset_ff)
    else $error("word write lost data or address");

  AST_READ_REFUSED: assert property (
    rd_valid && !rd_fetch && !read_protect_ff[rd_offset[11:10]] |=> rd_data_ff == 32'h0 && rd_refused_ff)
    else $error("protected data read not refused");

  AST_FETCH_PASSES: assert property (
    rd_valid && rd_fetch |=> rd_data_ff == $past(rd_array_data) && !rd_refused_ff)
    else $error("instruction fetch was refused");

  AST_CMD_STABLE: assert property (
    flash_cmd_ff.active && $past(flash_cmd_ff.active) |->
      $stable(flash_cmd_ff.op) && $stable(flash_cmd_ff.offset) && $stable(flash_cmd_ff.data))
    else $error("array command changed during pulse");

  AST_START_TARGET: assert property (
    start && !target_locked |=> flash_cmd_ff.offset == $past(offset_ff) && flash_cmd_ff.op == $past(nxt_op))
    else $error("operation started at wrong location or kind");

  AST_CMD_ONLY_UNLOCKED: assert property (
    $rose(flash_cmd_ff.active) && (flash_cmd_ff.op == flash_ctrl_pkg::OP_WORD_WRITE ||
      flash_cmd_ff.op == flash_ctrl_pkg::OP_PAGE_ERASE) |->
      program_protect_ff[flash_cmd_ff.offset[flash_ctrl_pkg::BLOCK_LSB +: 2]])
    else $error("program or erase issued to locked block");

  AST_PENDING_HOLDS: assert property (
    state_ff == flash_ctrl_pkg::SEQ_PULSE |=> op_bits_ff == $past(op_bits_ff))
    else $error("operation bit changed while pending");

  AST_ZERO_BITS_IGNORED: assert property (
    ctrl_wr && key_ok && pwdata[3:0] == 4'h0 && state_ff == flash_ctrl_pkg::SEQ_IDLE |=>
      op_bits_ff == 4'h0 && !flash_cmd_ff.active)
    else $error("write of zero bits started an operation");

  AST_TICK_COUNTS_DOWN: assert property (
    state_ff == flash_ctrl_pkg::SEQ_PULSE && tick_cnt_ff != 8'h00 |=> tick_cnt_ff == $past(tick_cnt_ff) - 8'h01)
    else $error("tick counter did not count down");

  AST_COMMIT_STROBE_ONE: assert property (
    nv_commit_ff.strobe |=> !nv_commit_ff.strobe)
    else $error("commit strobe longer than one cycle");

  AST_ADDR_FIELD: assert property (
    psel && penable && pready_ff && !pwrite && paddr == flash_ctrl_pkg::OFF_OP_ADDRESS |-> prdata_ff[31:12] == 20'h0)
    else $error("address register read beyond offset field");

  AST_PROTECT_FIELD: assert property (
    psel && penable && pready_ff && !pwrite && (paddr == flash_ctrl_pkg::OFF_READ_PROTECT ||
      paddr == flash_ctrl_pkg::OFF_PROGRAM_PROTECT) |-> prdata_ff[31:4] == 28'h0)
    else $error("protection register read beyond block bits");

  AST_RELOAD_FIELD: assert property (
    psel && penable && pready_ff && !pwrite && paddr == flash_ctrl_pkg::OFF_TICK_RELOAD |-> prdata_ff[31:8] == 24'h0)
    else $error("tick reload read beyond its field");

  COV_WORD_WRITE_DONE: cover property (
    flash_cmd_ff.active && flash_cmd_ff.op == flash_ctrl_pkg::OP_WORD_WRITE ##1 !flash_cmd_ff.active);
  COV_COMMIT: cover property (nv_commit_ff.strobe && nv_commit_ff.sel_program);
  COV_LOCKED_START: cover property (start && target_locked);
  COV_REFUSED_READ: cover property (rd_refused_ff);
  COV_PAGE_ERASE_DONE: cover property (
    flash_cmd_ff.active && flash_cmd_ff.op == flash_ctrl_pkg::OP_PAGE_ERASE ##1 !flash_cmd_ff.active);

endmodule

// ===== flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic                  pclk,
  input  flash_ctrl_pkg::flash_cmd_t flash_cmd,
  input  flash_ctrl_pkg::nv_commit_t nv_commit,
  input  wire logic [11:0]           rd_offset,
  output logic      [31:0]           rd_array_data,
  output logic      [3:0]            nv_read_protect,
  output logic      [3:0]            nv_program_protect
);
  logic [31:0] mem [0:1023];
  logic        act_ff;

  // factory state: erased array, every protection copy open
  initial begin
    foreach (mem[i]) mem[i] = 32'hffff_ffff;
    nv_read_protect = 4'hf;
    nv_program_protect = 4'hf;
    act_ff = 1'b0;
  end

  // array data comes back in the request cycle, fetch or data alike
  assign rd_array_data = mem[rd_offset[11:2]];

  always @(posedge pclk) begin
    act_ff <= flash_cmd.active;
    if (flash_cmd.active && !act_ff) begin
      case (flash_cmd.op)
        // programming can only pull bits low, like real cells
        flash_ctrl_pkg::OP_WORD_WRITE: mem[flash_cmd.offset[11:2]] <= mem[flash_cmd.offset[11:2]] & flash_cmd.data;
        flash_ctrl_pkg::OP_PAGE_ERASE: for (int i = 0; i < 256; i++) mem[{flash_cmd.offset[11:10], i[7:0]}] <= '1;
        flash_ctrl_pkg::OP_MASS_ERASE: for (int i = 0; i < 1024; i++) if (flash_cmd.erase_mask[i/256]) mem[i] <= '1;
        default: ;
      endcase
    end
    if (nv_commit.strobe) begin
      if (nv_commit.sel_program) nv_program_protect <= nv_commit.value;
      else nv_read_protect <= nv_commit.value;
    end
  end
endmodule

// ===== flash_program_erase_protect_ctrl_tb.sv
`timescale 1ns/1ps
module flash_program_erase_protect_ctrl_tb;
  localparam int unsigned RL = 39;
  localparam int DUR [4] = '{2, 3, 4, 2};
  logic                       pclk = 1'b0;
  logic                       presetn = 1'b0;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [11:0]                paddr = 12'h000;
  logic [31:0]                pwdata = 32'h0;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [3:0]                 nvr;
  logic [3:0]                 nvp;
  flash_ctrl_pkg::flash_cmd_t flash_cmd;
  flash_ctrl_pkg::nv_commit_t nv_commit;
  logic                       rd_valid = 1'b0;
  logic                       rd_fetch = 1'b0;
  logic [11:0]                rd_offset = 12'h000;
  logic [31:0]                rd_array_data;
  logic [31:0]                rd_data;
  logic                       rd_refused;
  logic [31:0]                rdat;
  logic [31:0]                wd;
  logic                       err;
  logic [11:0]                off;
  int                         mismatches = 0;
  int                         checks_done = 0;
  int                         act_cnt = 0;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (flash_cmd.active === 1'b1) act_cnt++;

  flash_program_erase_protect_ctrl #(.WORD_WRITE_US(DUR[0]), .PAGE_ERASE_US(DUR[1]), .MASS_ERASE_US(DUR[2]),
    .COMMIT_US(DUR[3])) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nv_read_protect(nvr),
    .nv_program_protect(nvp), .flash_cmd(flash_cmd), .nv_commit(nv_commit), .rd_valid(rd_valid),
    .rd_fetch(rd_fetch), .rd_offset(rd_offset), .rd_array_data(rd_array_data), .rd_data(rd_data),
    .rd_refused(rd_refused));

  flash_array_model model_u (.pclk(pclk), .flash_cmd(flash_cmd), .nv_commit(nv_commit), .rd_offset(rd_offset),
    .rd_array_data(rd_array_data), .nv_read_protect(nvr), .nv_program_protect(nvp));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // the answer is taken at the rising edge where pready is sampled high, or after 50 edges without it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mismatches++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask

  task automatic rst;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic arr_rd(input logic [11:0] a, input logic f, input logic [31:0] exp, input logic refd);
    @(posedge pclk);
    rd_valid <= 1'b1;
    rd_fetch <= f;
    rd_offset <= a;
    @(posedge pclk);
    rd_valid <= 1'b0;
    @(negedge pclk);
    chk("rd_data", rd_data, exp);
    chk("rd_refused", {31'h0, rd_refused}, {31'h0, refd});
  endtask

  function automatic logic span_ok(input int op, input int cnt);
    int e;
    e = DUR[op] * (RL + 1);
    return (cnt == e) || (cnt == e + 1);
  endfunction

  task automatic run_op(input int op, input logic [11:0] a, input logic ok);
    int n;
    n = 0;
    apb(1'b1, flash_ctrl_pkg::OFF_OP_ADDRESS, {20'h0, a});
    act_cnt = 0;
    apb(1'b1, flash_ctrl_pkg::OFF_OP_CONTROL, {16'ha442, 12'h0, 4'(1 << op)});
    rd(flash_ctrl_pkg::OFF_OP_CONTROL, ok ? 32'(1 << op) : 32'h0, "op_bits");
    if (ok) chk("cmd", {18'h0, flash_cmd.offset, flash_cmd.op}, {18'h0, a, 2'(op)});
    do begin
      apb(1'b0, flash_ctrl_pkg::OFF_OP_CONTROL, 32'h0);
      n++;
    end while (rdat !== 32'h0 && n < 100);
    chk("op_done", rdat, 32'h0);
    chk("span", {31'h0, ok ? span_ok(op, act_cnt) : (act_cnt == 0)}, 32'h1);
  endtask

  initial begin
    #500000;
    mismatches++;
    close_out;
  end

  initial begin
    void'($urandom(13));
    rst;
    rd(flash_ctrl_pkg::OFF_READ_PROTECT, 32'hf, "rd_prot");
    rd(flash_ctrl_pkg::OFF_PROGRAM_PROTECT, 32'hf, "pg_prot");
    rd(flash_ctrl_pkg::OFF_TICK_RELOAD, 32'h13, "reload");
    rd(flash_ctrl_pkg::OFF_OP_ADDRESS, 32'h0, "addr");
    rd(flash_ctrl_pkg::OFF_OP_CONTROL, 32'h0, "control");
    rd(12'h00c, 32'h0, "unmapped");
    chk("pslverr", {31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wd = $urandom;
      apb(1'b1, flash_ctrl_pkg::OFF_OP_ADDRESS, wd);
      rd(flash_ctrl_pkg::OFF_OP_ADDRESS, wd & 32'hfff, "addr");
      apb(1'b1, flash_ctrl_pkg::OFF_OP_DATA, wd);
      rd(flash_ctrl_pkg::OFF_OP_DATA, wd, "data");
      apb(1'b1, flash_ctrl_pkg::OFF_TICK_RELOAD, wd);
      rd(flash_ctrl_pkg::OFF_TICK_RELOAD, wd & 32'hff, "reload");
    end
    apb(1'b1, flash_ctrl_pkg::OFF_TICK_RELOAD, 32'(RL));
    act_cnt = 0;
    apb(1'b1, flash_ctrl_pkg::OFF_OP_CONTROL, 32'h1234_0001);
    rd(flash_ctrl_pkg::OFF_OP_CONTROL, 32'h0, "bad_key");
    chk("bad_key_act", 32'(act_cnt), 32'h0);
    off = 12'($urandom) & 12'h3fc;
    wd = $urandom;
    apb(1'b1, flash_ctrl_pkg::OFF_OP_DATA, wd);
    run_op(0, off, 1'b1);
    arr_rd(off, 1'b0, wd, 1'b0);
    run_op(1, off & 12'hc00, 1'b1);
    arr_rd(off, 1'b0, 32'hffff_ffff, 1'b0);
    run_op(2, 12'h000, 1'b1);
    apb(1'b1, flash_ctrl_pkg::OFF_READ_PROTECT, 32'hffff_fffd);
    rd(flash_ctrl_pkg::OFF_READ_PROTECT, 32'hd, "rd_prot");
    apb(1'b1, flash_ctrl_pkg::OFF_READ_PROTECT, 32'h0000_000f);
    rd(flash_ctrl_pkg::OFF_READ_PROTECT, 32'hd, "rd_prot_set");
    apb(1'b1, flash_ctrl_pkg::OFF_PROGRAM_PROTECT, 32'he);
    rd(flash_ctrl_pkg::OFF_PROGRAM_PROTECT, 32'he, "pg_prot");
    arr_rd(12'h400, 1'b0, 32'h0, 1'b1);
    arr_rd(12'h400, 1'b1, 32'hffff_ffff, 1'b0);
    apb(1'b1, flash_ctrl_pkg::OFF_OP_DATA, 32'h0);
    run_op(0, 12'h010, 1'b0);
    arr_rd(12'h010, 1'b0, 32'hffff_ffff, 1'b0);
    run_op(3, 12'h000, 1'b1);
    rst;
    rd(flash_ctrl_pkg::OFF_READ_PROTECT, 32'hd, "rd_prot_kept");
    rd(flash_ctrl_pkg::OFF_PROGRAM_PROTECT, 32'hf, "pg_prot_back");
    close_out;
  end
endmodule
